// >>> core/adcsp_map.vh
// constants of the serial output port of the measurement converter
// Summary of operation
// RULE_01: three-level mode pin picks port mode
// RULE_02: filter cycle 1024 clocks, starts at ready fall
// RULE_03: self-clocked idle: ready high at 1020, four cycles
// RULE_04: self-clocked polls at 76, then every 128
// RULE_05: host sets select low three clocks before poll
// RULE_06: poll low sends word msb first, clk/4
// RULE_07: host holds select low whole transfer
// RULE_08: select high: finish bit, float on clock low
// RULE_09: transfer done: ready rises, outputs float
// RULE_10: eighth window transfer postpones port reload
// RULE_11: external mode reloads every 1024, same ready timing
// RULE_12: external select seen at once except high interval
// RULE_13: external clock fall shifts next bit, then done
// RULE_14: host delays first clock rise after select
// RULE_15: external busy: no reload, ready stays low
// RULE_16: select high floats; unread kept until reload
// RULE_17: async mode sends two eleven-bit frames
// RULE_18: msb byte first, lsb after start bit
// RULE_19: async starts on clock fall latching select low
// RULE_20: select high ends frame after second stop
// RULE_21: host re-lowers select before ready rises
// RULE_22: select held low: reload after all 22 bits
// RULE_23: data changes on shift clock falling edge
// RULE_24: outputs float whenever no transfer active
`ifndef ADCSP_MAP_VH
`define ADCSP_MAP_VH
`define ADCSP_CYCLE 11'd1024
`define ADCSP_RDY_HIGH 11'd1020
`define ADCSP_POLL_FIRST 11'd75
`define ADCSP_POLL_STEP 11'd128
`define ADCSP_POLL_COUNT 4'd8
`define ADCSP_MODE_SELF 2'd0
`define ADCSP_MODE_EXT 2'd1
`define ADCSP_MODE_ASYNC 2'd2
`define ADCSP_FRAME_BITS 4'd11
`endif

// >>> core/adcsp_fifo.v
// the word fifo module is kept beside the port logic in adcsp_port.v

// >>> core/adcsp_port.v
// serial output port: self-clocked, external-clocked and async character modes
`timescale 1ns/1ns
`include "adcsp_map.vh"
module adcsp_port #(
   parameter WIDTH = 20, // 16 or 20 bit word
   parameter DEPTH = 8
) (
   input wire i_clk, // master clock
   input wire i_nrst, // async reset, low
   input wire i_mode_pos, // mode pin at positive digital supply
   input wire i_mode_neg, // mode pin at negative digital supply
   input wire [WIDTH-1:0] i_word, // conversion word from filter
   input wire i_word_valid, // conversion word valid
   output wire o_word_ready, // fifo can take a word
   input wire i_sel_n, // port select pin, low active
   input wire i_sclk, // shift clock pin (external/async modes)
   output reg o_sclk, // shift clock driven in self-clocked mode
   output reg o_sclk_oe, // shift clock drive enable
   output reg o_serial_data_out, // serial data
   output reg o_serial_data_oe, // serial data drive enable
   output reg o_word_ready_n // word ready strobe, low active
);
   localparam ST_IDLE = 2'd0;
   localparam ST_SHIFT = 2'd1;
   localparam ST_FRAME = 2'd2;
   localparam ST_HOLD = 2'd3;
   wire [31:0] msb_full = WIDTH - 1;
   wire [4:0] msb_idx = msb_full[4:0];
   reg [1:0] sel_s1_reg, sel_s2_reg;
   reg [1:0] mode_s1_reg, mode_s2_reg;
   reg [1:0] clk_s1_reg, clk_s2_reg;
   reg sclk_prev_reg;
   wire sel_low = !sel_s2_reg[0];
   wire sclk_lvl = clk_s2_reg[0];
   wire sclk_fall = sclk_prev_reg && !sclk_lvl;
   reg [1:0] mode_reg;
   reg [10:0] cyc_reg;
   reg [WIDTH-1:0] port_reg;
   reg [1:0] state_reg;
   reg [4:0] bit_reg;
   reg [1:0] div_reg;
   reg [3:0] fbit_reg;
   reg frame2_reg;
   reg pend_reg;
   reg post_reg;
   reg [7:0] sel_hist_reg;
   wire fifo_valid;
   wire [WIDTH-1:0] fifo_data;
   wire reload_t;
   adcsp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(3)) u_fifo (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_valid(i_word_valid),
      .o_ready(o_word_ready),
      .i_data(i_word),
      .o_valid(fifo_valid),
      .i_ready(reload_t),
      .o_data(fifo_data)
   );
   // one bit of the held word, picked by index
   function pick_bit;
      input [WIDTH-1:0] w;
      input [4:0] idx;
      begin
         pick_bit = w[idx];
      end
   endfunction
   wire at_poll = (cyc_reg >= `ADCSP_POLL_FIRST) && (cyc_reg[6:0] == `ADCSP_POLL_FIRST % 128);
   wire [10:0] poll_off = cyc_reg - `ADCSP_POLL_FIRST;
   wire [2:0] poll_idx = poll_off[9:7];
   wire busy = (state_reg != ST_IDLE);
   // reload instant: end of the four-cycle high interval, not while a transfer holds data
   wire at_end = (cyc_reg == `ADCSP_CYCLE - 11'd1);
   // deselected external transfer keeps its bits only until the next update
   wire ext_free = (mode_reg == `ADCSP_MODE_EXT) && (state_reg == ST_IDLE) && !sel_low; // RULE_16
   wire blocked = busy || (pend_reg && !ext_free) || post_reg; // RULE_15 RULE_22
   assign reload_t = at_end && !blocked && fifo_valid;
   wire high_win = (cyc_reg >= `ADCSP_RDY_HIGH);
   // port select held low three master clocks before the poll
   wire sel_setup = (sel_hist_reg[2:0] == 3'b000); // RULE_05
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sel_s1_reg <= 2'b11;
         sel_s2_reg <= 2'b11;
         clk_s1_reg <= 2'b00;
         clk_s2_reg <= 2'b00;
         sclk_prev_reg <= 1'b0;
         sel_hist_reg <= 8'hff;
         mode_s1_reg <= 2'b00;
         mode_s2_reg <= 2'b00;
      end else begin
         mode_s1_reg <= {i_mode_pos, i_mode_neg};
         mode_s2_reg <= mode_s1_reg;
         sel_s1_reg <= {1'b1, i_sel_n};
         sel_s2_reg <= sel_s1_reg;
         clk_s1_reg <= {1'b0, i_sclk};
         clk_s2_reg <= clk_s1_reg;
         sclk_prev_reg <= sclk_lvl;
         sel_hist_reg <= {sel_hist_reg[6:0], sel_s2_reg[0]};
      end
   end
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mode_reg <= `ADCSP_MODE_EXT;
         cyc_reg <= 11'd0;
         port_reg <= {WIDTH{1'b0}};
         state_reg <= ST_IDLE;
         bit_reg <= 5'd0;
         div_reg <= 2'd0;
         fbit_reg <= 4'd0;
         frame2_reg <= 1'b0;
         pend_reg <= 1'b0;
         post_reg <= 1'b0;
         o_sclk <= 1'b0;
         o_sclk_oe <= 1'b0;
         o_serial_data_out <= 1'b0;
         o_serial_data_oe <= 1'b0; // RULE_24
         o_word_ready_n <= 1'b1;
      end else begin
         // mode pin levels are static straps, taken at a cycle wrap when no transfer is active
         if (cyc_reg == 11'd0 && !busy)
            mode_reg <= mode_s2_reg[1] ? `ADCSP_MODE_SELF : (mode_s2_reg[0] ? `ADCSP_MODE_ASYNC : `ADCSP_MODE_EXT); // RULE_01
         // filter cycle counter, ready falls at count zero
         cyc_reg <= at_end ? 11'd0 : cyc_reg + 11'd1; // RULE_02
         if (at_end && !blocked) begin
            if (reload_t)
               port_reg <= fifo_data; // RULE_11
            pend_reg <= 1'b0; // RULE_16
            o_word_ready_n <= 1'b0;
         end else if (cyc_reg == `ADCSP_RDY_HIGH - 11'd1 && !blocked && !(state_reg == ST_HOLD)) begin
            o_word_ready_n <= 1'b1; // RULE_03 RULE_11 RULE_19
         end
         if (at_end)
            post_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               o_serial_data_oe <= 1'b0; // RULE_24
               o_sclk_oe <= 1'b0;
               frame2_reg <= 1'b0;
               if (mode_reg == `ADCSP_MODE_SELF) begin
                  if (at_poll && sel_low && sel_setup && !o_word_ready_n) begin // RULE_04
                     state_reg <= ST_SHIFT;
                     bit_reg <= msb_idx;
                     div_reg <= 2'd0;
                     o_sclk_oe <= 1'b1;
                     o_sclk <= 1'b0;
                     o_serial_data_oe <= 1'b1;
                     o_serial_data_out <= pick_bit(port_reg, msb_idx); // RULE_06
                     pend_reg <= 1'b1;
                     if (poll_idx == 3'd7)
                        post_reg <= 1'b1; // RULE_10
                  end
               end else if (mode_reg == `ADCSP_MODE_EXT) begin
                  if (sel_low && !high_win && !o_word_ready_n) begin // RULE_12
                     state_reg <= ST_SHIFT;
                     o_serial_data_oe <= 1'b1;
                     o_serial_data_out <= pick_bit(port_reg, bit_reg);
                     if (!pend_reg) begin
                        bit_reg <= msb_idx;
                        o_serial_data_out <= pick_bit(port_reg, msb_idx);
                     end
                     pend_reg <= 1'b1;
                  end
               end else begin
                  if (sclk_fall && sel_low && !o_word_ready_n && !high_win) begin // RULE_19
                     state_reg <= ST_FRAME;
                     fbit_reg <= 4'd0;
                     o_serial_data_oe <= 1'b1;
                     o_serial_data_out <= 1'b0;
                     pend_reg <= 1'b1;
                  end else if (pend_reg && frame2_reg == 1'b0 && sel_low && !high_win) begin
                     state_reg <= ST_FRAME; // RULE_21
                  end
               end
            end
            ST_SHIFT: begin
               if (mode_reg == `ADCSP_MODE_SELF) begin
                  div_reg <= div_reg + 2'd1;
                  if (div_reg == 2'd1)
                     o_sclk <= 1'b1;
                  if (div_reg == 2'd3) begin
                     o_sclk <= 1'b0;
                     if (bit_reg == 5'd0 || !sel_low) begin // RULE_08 RULE_07
                        state_reg <= ST_IDLE;
                        o_sclk_oe <= 1'b0;
                        o_serial_data_oe <= 1'b0;
                        pend_reg <= 1'b0;
                        if (bit_reg == 5'd0)
                           o_word_ready_n <= 1'b1; // RULE_09
                     end else begin
                        bit_reg <= bit_reg - 5'd1;
                        o_serial_data_out <= port_reg[bit_reg-5'd1]; // RULE_23
                     end
                  end
               end else begin
                  if (!sel_low) begin
                     state_reg <= ST_IDLE;
                     o_serial_data_oe <= 1'b0; // RULE_16
                     if (at_end || high_win)
                        pend_reg <= 1'b0;
                  end else if (sclk_fall) begin // RULE_13 RULE_23
                     if (bit_reg == 5'd0) begin
                        state_reg <= ST_IDLE;
                        o_serial_data_oe <= 1'b0;
                        pend_reg <= 1'b0;
                        o_word_ready_n <= 1'b1;
                     end else begin
                        bit_reg <= bit_reg - 5'd1;
                        o_serial_data_out <= port_reg[bit_reg-5'd1];
                     end
                  end
               end
            end
            ST_FRAME: begin
               o_serial_data_oe <= 1'b1;
               if (sclk_fall) begin // RULE_17 RULE_23
                  fbit_reg <= fbit_reg + 4'd1;
                  if (fbit_reg < 4'd8)
                     o_serial_data_out <= port_reg[{~frame2_reg, fbit_reg[2:0]}]; // RULE_18
                  else
                     o_serial_data_out <= 1'b1;
                  if (fbit_reg == `ADCSP_FRAME_BITS - 4'd1) begin // RULE_20
                     fbit_reg <= 4'd0;
                     if (frame2_reg) begin
                        state_reg <= ST_IDLE;
                        o_serial_data_oe <= 1'b0;
                        pend_reg <= 1'b0; // RULE_22
                        o_word_ready_n <= 1'b1;
                     end else begin
                        frame2_reg <= 1'b1;
                        if (sel_low)
                           o_serial_data_out <= 1'b0;
                        else begin
                           state_reg <= ST_HOLD;
                           o_serial_data_oe <= 1'b0;
                        end
                     end
                  end
               end
            end
            default: begin
               o_serial_data_oe <= 1'b0;
               if (sel_low) begin
                  state_reg <= ST_FRAME; // RULE_21
                  o_serial_data_oe <= 1'b1;
                  o_serial_data_out <= 1'b0;
               end else if (cyc_reg == `ADCSP_RDY_HIGH - 11'd1) begin
                  state_reg <= ST_IDLE;
                  pend_reg <= 1'b0;
                  o_word_ready_n <= 1'b1;
               end
            end
         endcase
      end
   end
endmodule // adcsp_port

// small valid/ready fifo feeding conversion words to the port
module adcsp_fifo #(
   parameter WIDTH = 20,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire i_clk, // clock
   input wire i_nrst, // async reset, low
   input wire i_valid, // write valid
   output wire o_ready, // not full, registered
   input wire [WIDTH-1:0] i_data, // write data
   output wire o_valid, // not empty
   input wire i_ready, // read accept
   output wire [WIDTH-1:0] o_data // head word
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_reg;
   reg [AW-1:0] rd_reg;
   reg [AW:0] cnt_reg;
   reg [AW:0] cnt_next;
   reg rdy_reg;
   wire do_wr = i_valid && rdy_reg;
   wire do_rd = i_ready && (cnt_reg != {(AW+1){1'b0}});
   // ready is a flop so the port's top-level output needs no logic after it
   assign o_ready = rdy_reg;
   assign o_valid = (cnt_reg != {(AW+1){1'b0}});
   assign o_data = mem[rd_reg];
   always @* begin
      cnt_next = cnt_reg;
      if (do_wr && !do_rd)
         cnt_next = cnt_reg + 1'b1;
      else if (do_rd && !do_wr)
         cnt_next = cnt_reg - 1'b1;
   end
   always @(posedge i_clk) begin
      if (do_wr)
         mem[wr_reg] <= i_data;
   end
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_reg <= {AW{1'b0}};
         rd_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
         rdy_reg <= 1'b1;
      end else begin
         if (do_wr)
            wr_reg <= wr_reg + 1'b1;
         if (do_rd)
            rd_reg <= rd_reg + 1'b1;
         cnt_reg <= cnt_next;
         rdy_reg <= (cnt_next != DEPTH);
      end
   end
endmodule // adcsp_fifo

// >>> bench/adcsp_port_checker.sv
// assertions on strobe, shift clock and data timing of the port
`timescale 1ns/1ns
module adcsp_port_checker (
   input wire i_clk, // master clock
   input wire i_nrst, // reset, low
   input wire i_sel_n, // port select
   input wire o_sclk, // driven shift clock
   input wire o_sclk_oe, // shift clock enable
   input wire o_serial_data_out, // data
   input wire o_serial_data_oe, // data enable
   input wire o_word_ready_n // word ready, low
);
   reg [10:0] cnt_reg;
   reg armed_reg;
   // cycles since the last ready fall
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_reg <= 11'h000;
         armed_reg <= 1'b0;
      end else begin
         cnt_reg <= $fell(o_word_ready_n) ? 11'h000 : cnt_reg + 11'h001;
         armed_reg <= armed_reg | $fell(o_word_ready_n);
      end
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   sequence s_idle_rise;
      $rose(o_word_ready_n) && !$past(o_serial_data_oe) && armed_reg;
   endsequence
   sequence s_gap;
      o_word_ready_n [*4] ##1 !o_word_ready_n;
   endsequence
   chk_cycle_grid: assert property ($fell(o_word_ready_n) && armed_reg |-> cnt_reg[9:0] == 10'h3ff)
      else $error("ready fall off cycle grid");
   chk_idle_rise: assert property (s_idle_rise |-> cnt_reg == 11'h3fb)
      else $error("idle ready rise late or early");
   chk_high_gap: assert property (s_idle_rise |-> s_gap)
      else $error("ready high interval wrong");
   chk_reset_float: assert property ($rose(i_nrst) |-> !o_serial_data_oe && !o_sclk_oe && o_word_ready_n)
      else $error("outputs driven after reset");
   chk_sel_cause: assert property ($rose(o_serial_data_oe) |-> !$past(i_sel_n, 2))
      else $error("data driven without select");
   chk_sclk_high: assert property (o_sclk_oe && $rose(o_sclk) |-> ##1 o_sclk ##1 (!o_sclk || !o_sclk_oe))
      else $error("shift clock high phase wrong");
   chk_sclk_low: assert property (o_sclk_oe && $fell(o_sclk) |-> ##1 (!o_sclk || !o_sclk_oe))
      else $error("shift clock low phase wrong");
   chk_data_hold: assert property (o_sclk_oe && o_sclk && $past(o_sclk) |-> $stable(o_serial_data_out))
      else $error("data moved while clock high");
   chk_float_pair: assert property ($fell(o_sclk_oe) |-> !o_serial_data_oe)
      else $error("data still driven after clock float");
   chk_done_ready: assert property ($fell(o_sclk_oe) && !i_sel_n |-> ##[0:2] o_word_ready_n)
      else $error("ready not raised at transfer end");
   chk_poll_grid: assert property ($rose(o_sclk_oe) |-> cnt_reg >= 11'h04b && ((cnt_reg - 11'h04b) & 11'h07f) <= 11'h006)
      else $error("transfer start off poll grid");
endmodule // adcsp_port_checker
bind adcsp_port adcsp_port_checker i_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_sel_n(i_sel_n), .o_sclk(o_sclk),
   .o_sclk_oe(o_sclk_oe), .o_serial_data_out(o_serial_data_out), .o_serial_data_oe(o_serial_data_oe),
   .o_word_ready_n(o_word_ready_n));

// >>> bench/adcsp_host_model.sv
// far-side receiver: makes the external shift clock and captures serial data
`timescale 1ns/1ns
module adcsp_host_model (
   input wire i_data, // serial data pin
   input wire i_data_oe, // data drive enable
   input wire i_sclk_dev, // device shift clock
   input wire i_sclk_dev_oe, // its enable
   output reg o_sclk // shift clock to device
);
   reg last_reg = 1'b0;
   reg [63:0] bits = 64'h0;
   reg [63:0] drv = 64'h0;
   integer cnt = 0;
   // released line shows the inverse of its last driven value
   wire data_line = i_data_oe ? i_data : ~last_reg;
   wire dev_clk = i_sclk_dev & i_sclk_dev_oe;
   initial o_sclk = 1'b0;
   always @(i_data or i_data_oe) if (i_data_oe) last_reg = i_data;
   task grab;
      begin
         bits = {bits[62:0], data_line};
         drv = {drv[62:0], i_data_oe};
         cnt = cnt + 1;
      end
   endtask
   always @(posedge dev_clk) grab;
   // sample late in each bit so the device's sync delay is covered
   task clock_bits(input integer n, input reg idle);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            if (idle) begin
               o_sclk = 1'b0;
               #160;
            end
            o_sclk = 1'b1;
            #150;
            grab;
            #10;
            if (!idle) begin
               o_sclk = 1'b0;
               #160;
            end
         end
      end
   endtask
endmodule // adcsp_host_model

// >>> bench/tb_top.sv
// testbench for the serial output port
`timescale 1ns/1ns
module tb_top;
   reg i_clk, i_nrst, i_mode_pos, i_mode_neg, i_word_valid, i_sel_n;
   reg [19:0] i_word;
   reg [19:0] exp_word;
   wire o_word_ready, dut_sclk, dut_sclk_oe, data, data_oe, rdy_n, host_sclk;
   wire sclk_pin = dut_sclk_oe ? dut_sclk : host_sclk;
   integer bad_count = 0, total_checks = 0, pop_cnt = 0, push_cnt = 0;
   adcsp_port #(.WIDTH(20), .DEPTH(8)) i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_mode_pos(i_mode_pos),
      .i_mode_neg(i_mode_neg), .i_word(i_word), .i_word_valid(i_word_valid), .o_word_ready(o_word_ready),
      .i_sel_n(i_sel_n), .i_sclk(sclk_pin), .o_sclk(dut_sclk), .o_sclk_oe(dut_sclk_oe),
      .o_serial_data_out(data), .o_serial_data_oe(data_oe), .o_word_ready_n(rdy_n));
   adcsp_host_model i_host (.i_data(data), .i_data_oe(data_oe), .i_sclk_dev(dut_sclk),
      .i_sclk_dev_oe(dut_sclk_oe), .o_sclk(host_sclk));
   function [19:0] pat(input integer k);
      pat = {k[7:0], 12'h5a3} ^ 20'h3c000;
   endfunction
   function [7:0] rev8(input [7:0] v);
      integer b;
      for (b = 0; b < 8; b = b + 1) rev8[b] = v[7 - b];
   endfunction
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   always @(posedge i_clk) if (i_nrst && i_word_valid && o_word_ready) push_cnt <= push_cnt + 1;
   always @(negedge i_clk) i_word <= pat(push_cnt);
   always @(negedge rdy_n) pop_cnt = pop_cnt + 1;
   task check(input [63:0] seen, input [63:0] want);
      begin
         total_checks = total_checks + 1;
         if (seen !== want) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
         end
      end
   endtask
   task complete_run;
      begin
         if (bad_count == 0 && total_checks > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   task wait_fall;
      integer n, i;
      begin
         n = pop_cnt;
         for (i = 0; i < 2100 && pop_cnt == n; i = i + 1) @(negedge i_clk);
         if (pop_cnt == n) begin
            bad_count = bad_count + 1;
            complete_run;
         end
         exp_word = pat(pop_cnt - 1);
      end
   endtask
   task t_idle;
      integer k;
      begin
         check({o_word_ready, push_cnt[7:0], data_oe, dut_sclk_oe, rdy_n}, 12'h041);
         wait_fall;
         for (k = 0; rdy_n === 1'b0 && k < 1100; k = k + 1) @(negedge i_clk);
         check(k, 1020);
         for (k = 0; rdy_n === 1'b1 && k < 10; k = k + 1) @(negedge i_clk);
         check(k, 4);
      end
   endtask
   task t_ext;
      begin
         wait_fall;
         i_sel_n = 1'b0;
         repeat (8) @(negedge i_clk);
         check(data_oe, 1);
         i_host.clock_bits(4, 1'b0);
         @(negedge i_clk);
         i_sel_n = 1'b1;
         repeat (4) @(negedge i_clk);
         check(data_oe, 0);
         i_sel_n = 1'b0;
         repeat (8) @(negedge i_clk);
         i_host.clock_bits(16, 1'b0);
         repeat (6) @(negedge i_clk);
         check(i_host.bits[19:0], exp_word);
         check({data_oe, rdy_n}, 2'b01);
         i_sel_n = 1'b1;
      end
   endtask
   task t_self;
      integer n, i;
      begin
         i_mode_pos = 1'b1;
         wait_fall;
         i_sel_n = 1'b0;
         n = i_host.cnt;
         for (i = 0; i < 700 && i_host.cnt < n + 20; i = i + 1) @(negedge i_clk);
         if (i == 700) begin
            bad_count = bad_count + 1;
            complete_run;
         end
         repeat (4) @(negedge i_clk);
         check(i_host.bits[19:0], exp_word);
         check({dut_sclk_oe, data_oe, rdy_n}, 3'b001);
         i_sel_n = 1'b1;
         i_mode_pos = 1'b0;
      end
   endtask
   task t_async;
      integer j;
      begin
         i_mode_neg = 1'b1;
         wait_fall;
         i_sel_n = 1'b0;
         repeat (4) @(negedge i_clk);
         check(data_oe, 0);
         i_host.clock_bits(40, 1'b1);
         @(negedge i_clk);
         for (j = 39; j > 21 && !i_host.drv[j]; j = j - 1) @(negedge i_clk);
         check(i_host.bits[j -: 22], {1'b0, rev8(exp_word[15:8]), 3'b110, rev8(exp_word[7:0]), 2'b11});
         check(data_oe, 0);
         i_sel_n = 1'b1;
      end
   endtask
   task t_async_gap;
      begin
         wait_fall;
         i_sel_n = 1'b0;
         repeat (4) @(negedge i_clk);
         i_host.clock_bits(1, 1'b1);
         @(negedge i_clk);
         i_sel_n = 1'b1;
         i_host.clock_bits(11, 1'b1);
         @(negedge i_clk);
         check(data_oe, 0);
         i_sel_n = 1'b0;
         repeat (4) @(negedge i_clk);
         check(data_oe, 1);
         i_host.clock_bits(11, 1'b1);
         repeat (4) @(negedge i_clk);
         check(i_host.bits[22:12], {1'b0, rev8(exp_word[15:8]), 2'b11});
         check(i_host.bits[10:1], {rev8(exp_word[7:0]), 2'b11});
         check({data_oe, rdy_n}, 2'b01);
         i_sel_n = 1'b1;
         i_mode_neg = 1'b0;
      end
   endtask
   initial begin
      i_nrst = 1'b0;
      i_mode_pos = 1'b0;
      i_mode_neg = 1'b0;
      i_word_valid = 1'b1;
      i_sel_n = 1'b1;
      i_word = 20'h00000;
      repeat (3) @(negedge i_clk);
      i_nrst = 1'b1;
      repeat (20) @(negedge i_clk);
      t_idle;
      t_ext;
      t_self;
      t_async;
      t_async_gap;
      complete_run;
   end
endmodule // tb_top
